// File: verilog/disc_order_phase_sequencer.sv
// Phase sequencer and order decoder of the disc file controller
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module disc_order_phase_sequencer (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Processor side pins
   input wire disc_seq_pkg::pins_s pins_in,
   output disc_seq_pkg::status_s status_out,
   output logic [disc_seq_pkg::IND_W-1:0] indicator_out,
   output logic [7:0] unit_select
);
   import disc_seq_pkg::*;

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [PIN_W-1:0] s1_r, s2_r, s3_r, filt_r;
   pins_s pf;
   genvar gi;
   // Change accepted only when stages two and three agree
   generate
      for (gi = 0; gi < PIN_W; gi++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1_r[gi] <= 1'b0;
               s2_r[gi] <= 1'b0;
               s3_r[gi] <= 1'b0;
               filt_r[gi] <= 1'b0;
            end else begin
               s1_r[gi] <= pins_in[gi];
               s2_r[gi] <= s1_r[gi];
               s3_r[gi] <= s2_r[gi];
               if (s2_r[gi] == s3_r[gi]) filt_r[gi] <= s3_r[gi];
            end
         end
      end
   endgenerate
   assign pf = pins_s'(filt_r);

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   logic [31:0] ctrl_r;
   logic step_r, strobe_d_r;
   wire setup = psel && !penable;
   wire access = psel && penable && pready;
   wire hit_ctrl = (paddr == ADDR_CTRL);
   wire hit_step = (paddr == ADDR_STEP);
   wire hit_stat = (paddr == ADDR_STATUS);
   wire hit_seek = (paddr == ADDR_SEEK);
   wire mapped = hit_ctrl || hit_step || hit_stat || hit_seek;
   wire wr_ctrl = access && pwrite && hit_ctrl;
   wire wr_step = access && pwrite && hit_step && pwdata[STEP_BIT];
   wire single = ctrl_r[CTRL_SINGLE];
   wire clr = pf.tester_reset;

   // ---------------------------------------------------------------
   // Phase machine state
   // ---------------------------------------------------------------
   phase_e phase_r, phase_nxt;
   cycle_e cyc_r;
   logic busy_r, data_r, inb_r, une_r, sun_r, pend_r, byte_r, tof_r;
   logic [3:0] order_r;
   logic [TRACK_W-1:0] track_r;
   logic [SECTOR_W-1:0] sector_r;
   logic [3:0] cmd_r;

   // Free-run advances every clock; single phase only on a step pulse
   wire adv = single ? step_r : 1'b1;
   wire strobe_rise = pf.function_strobe && !strobe_d_r;
   wire start_cmd = cmd_r[0];
   wire is_seek = (order_r == ORD_SEEK);
   // Only five order codes are legal
   wire legal = (order_r == ORD_WRITE) || (order_r == ORD_READ) ||
      is_seek || (order_r == ORD_SENSE) || (order_r == ORD_CHKWR);
   // Byte 0: overflow then high track; byte 1: low track then sector
   wire [TRACK_W-1:0] trk_in = {track_r[TRACK_W-1:SECTOR_W], pf.data[7:SECTOR_W]};
   wire seek_err = tof_r || track_r[TRACK_W-1] || track_r[TRACK_W-2] ||
      (sector_r[SECTOR_W-1] && sector_r[SECTOR_W-2]);
   wire go = (phase_nxt != phase_r);
   wire svc_done = go && (phase_r == service_phase);
   wire tout_done = go && (phase_r == transfer_out_phase);
   wire late_done = go && (phase_r == strobe_late_phase);

   // Next phase
   always_comb begin
      phase_nxt = phase_r;
      case (phase_r)
         strobe_wait_phase: begin
            if (strobe_rise) phase_nxt = strobe_ack_phase;
            else if (pend_r && adv) phase_nxt = strobe_ack_phase;
         end
         strobe_ack_phase: if (adv) phase_nxt = strobe_late_phase;
         strobe_late_phase: begin
            // Not yet busy: halt, test and a fresh start all go straight back to wait
            if (adv) phase_nxt = busy_r ? service_request_phase : strobe_wait_phase;
         end
         service_request_phase: if (adv) phase_nxt = service_phase;
         service_phase: if (adv) phase_nxt = transfer_out_phase;
         transfer_out_phase: if (adv) phase_nxt = strobe_wait_phase;
         default: phase_nxt = strobe_wait_phase;
      endcase
   end

   // Phase and strobe edge registers; tester reset also returns to wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= strobe_wait_phase;
         strobe_d_r <= 1'b0;
      end else begin
         strobe_d_r <= pf.function_strobe;
         phase_r <= clr ? strobe_wait_phase : phase_nxt;
      end
   end

   // Command captured with the strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cmd_r <= 4'h0;
      else if (strobe_rise && phase_r == strobe_wait_phase)
         cmd_r <= {pf.halt_indicator, pf.device_test_indicator,
            pf.io_test_indicator, pf.start_indicator};
   end

   // Flags and service cycle bookkeeping
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_r <= 1'b0;
         data_r <= 1'b0;
         inb_r <= 1'b0;
         une_r <= 1'b0;
         sun_r <= 1'b0;
         pend_r <= 1'b0;
         byte_r <= 1'b0;
         cyc_r <= CYC_ORDER_OUT;
      end else if (clr) begin
         busy_r <= 1'b0;
         data_r <= 1'b0;
         inb_r <= 1'b0;
         pend_r <= 1'b0;
         cyc_r <= CYC_ORDER_OUT;
      end else begin
         if (late_done && !busy_r && start_cmd) begin
            busy_r <= 1'b1;
            pend_r <= 1'b1;
            une_r <= 1'b0;
            sun_r <= 1'b0;
            cyc_r <= CYC_ORDER_OUT;
         end
         if (svc_done && cyc_r == CYC_DATA && !legal) une_r <= 1'b1;
         if (tout_done) begin
            case (cyc_r)
               CYC_ORDER_OUT: begin
                  cyc_r <= CYC_DATA;
                  data_r <= 1'b1;
                  byte_r <= 1'b0;
               end
               CYC_DATA: begin
                  if (is_seek && !byte_r) byte_r <= 1'b1;
                  else begin
                     cyc_r <= CYC_ORDER_IN;
                     data_r <= 1'b0;
                     inb_r <= 1'b1;
                     if (is_seek && seek_err) begin
                        sun_r <= 1'b1;
                        une_r <= 1'b1;
                     end
                  end
               end
               CYC_ORDER_IN: begin
                  busy_r <= 1'b0;
                  inb_r <= 1'b0;
                  pend_r <= 1'b0;
                  cyc_r <= CYC_ORDER_OUT;
               end
               default: cyc_r <= CYC_ORDER_OUT;
            endcase
         end
      end
   end

   // Order and seek address, taken while the service phase ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         order_r <= 4'h0;
         track_r <= '0;
         sector_r <= '0;
         tof_r <= 1'b0;
      end else begin
         if (svc_done && cyc_r == CYC_ORDER_OUT) order_r <= pf.data[3:0];
         if (svc_done && cyc_r == CYC_DATA && is_seek) begin
            if (!byte_r) begin
               tof_r <= pf.data[7];
               track_r <= {pf.data[6:0], track_r[SECTOR_W-1:0]};
            end else begin
               track_r <= trk_in;
               sector_r <= pf.data[SECTOR_W-1:0];
            end
         end
         // Step to next track after each non-seek operation unless held
         if (tout_done && cyc_r == CYC_ORDER_IN && !is_seek && !pf.hold_track)
            track_r <= track_r + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Registers and outputs
   // ---------------------------------------------------------------
   status_s stat_nxt;
   logic [IND_W-1:0] ind_nxt;
   logic [31:0] rd_nxt;
   // Phase word is one-hot by construction of the enum decode
   assign stat_nxt.phase_hot = 6'(1) << phase_r;
   assign stat_nxt.controller_busy_flag = busy_r;
   assign stat_nxt.data_flag = data_r;
   assign stat_nxt.inbound_flag = inb_r;
   assign stat_nxt.unusual_end_flag = une_r;
   assign stat_nxt.sector_unavailable_flag = sun_r;
   // CTRL_INDUP set shows the seek address on all indicators, clear shows the sequencer
   assign ind_nxt = ctrl_r[CTRL_INDUP] ? {tof_r, track_r, sector_r}
      : {stat_nxt, order_r, 1'b0};
   assign rd_nxt = hit_ctrl ? ctrl_r
      : hit_stat ? {19'h0, cyc_r, stat_nxt}
      : hit_seek ? {11'h0, tof_r, track_r, sector_r, 1'b0, order_r}
      : 32'h0000_0000;

   // Zero wait states: answer is ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RESET;
         step_r <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) ctrl_r <= pwdata;
         step_r <= wr_step;
         pready <= setup;
         pslverr <= setup && !mapped;
         if (setup && !pwrite) prdata <= rd_nxt;
      end
   end

   // Status, indicators and unit select, all registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_out <= '0;
         indicator_out <= '0;
         unit_select <= 8'h00;
      end else begin
         status_out <= stat_nxt;
         indicator_out <= ind_nxt;
         unit_select <= 8'(1) << ctrl_r[CTRL_UNIT_LO +: UNIT_W];
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   reset_to_wait_a: assert property (clr |=> phase_r == strobe_wait_phase)
      else $error("reset did not force strobe wait");
   strobe_to_ack_a: assert property (disable iff (!presetn || clr)
      phase_r == strobe_wait_phase && strobe_rise |=> phase_r == strobe_ack_phase)
      else $error("strobe did not enter acknowledge");
   single_step_hold_a: assert property (disable iff (!presetn || clr)
      single && !step_r && phase_r != strobe_wait_phase |=> $stable(phase_r))
      else $error("phase moved without a step");
   test_cmd_return_a: assert property (disable iff (!presetn || clr)
      phase_r == strobe_late_phase && adv && !busy_r
      |=> phase_r == strobe_wait_phase)
      else $error("test command did not return to wait");
   start_busy_set_a: assert property (disable iff (!presetn || clr)
      phase_r == strobe_late_phase && adv && !busy_r && start_cmd
      |=> busy_r && phase_r == strobe_wait_phase ##1 pend_r)
      else $error("start did not set busy");
   illegal_order_a: assert property (disable iff (!presetn || clr)
      svc_done && cyc_r == CYC_DATA && !legal |=> une_r)
      else $error("illegal order missed unusual end");
   sector_error_a: assert property (disable iff (!presetn || clr)
      tout_done && cyc_r == CYC_DATA && is_seek && byte_r && seek_err
      |=> sun_r && une_r && cyc_r == CYC_ORDER_IN)
      else $error("sector error not flagged");
   order_in_end_a: assert property (disable iff (!presetn || clr)
      tout_done && cyc_r == CYC_ORDER_IN
      |=> !busy_r && !inb_r && phase_r == strobe_wait_phase)
      else $error("order in did not clear flags");
   hold_track_a: assert property (pf.hold_track && !svc_done |=> $stable(track_r))
      else $error("track moved while held");
   one_phase_a: assert property ($onehot(status_out.phase_hot) || $past(!presetn))
      else $error("phase word not one-hot");
   legal_code_a: assert property (legal |-> order_r >= ORD_WRITE && order_r <= ORD_CHKWR)
      else $error("illegal code decoded as legal");
   data_flag_a: assert property (disable iff (!presetn || clr)
      tout_done && cyc_r == CYC_ORDER_OUT |=> data_r && cyc_r == CYC_DATA)
      else $error("order out did not raise data flag");
   seek_byte_a: assert property (disable iff (!presetn || clr)
      svc_done && cyc_r == CYC_DATA && is_seek && !byte_r
      |=> tof_r == $past(pf.data[7]) && track_r[TRACK_W-1:SECTOR_W] == $past(pf.data[6:0]))
      else $error("seek byte zero not stored");
   overflow_error_a: assert property (disable iff (!presetn || clr)
      tout_done && cyc_r == CYC_DATA && is_seek && byte_r
      && (tof_r || track_r[TRACK_W-1] || track_r[TRACK_W-2]) |=> sun_r && une_r)
      else $error("track overflow not flagged");
   unit_onehot_a: assert property ($onehot(unit_select) || $past(!presetn))
      else $error("unit select not one-hot");

endmodule // disc_order_phase_sequencer

// File: verilog/disc_seq_pkg.sv
// Constants, types and carriers shared by the disc order phase sequencer
package disc_seq_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STEP = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_SEEK = 8'h0C;
   localparam int CTRL_SINGLE = 0;
   localparam int CTRL_INDUP = 1;
   localparam int CTRL_UNIT_LO = 2;
   localparam int UNIT_W = 3;
   localparam int STEP_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Order codes and seek layout
   // ---------------------------------------------------------------
   localparam logic [3:0] ORD_WRITE = 4'h1;
   localparam logic [3:0] ORD_READ = 4'h2;
   localparam logic [3:0] ORD_SEEK = 4'h3;
   localparam logic [3:0] ORD_SENSE = 4'h4;
   localparam logic [3:0] ORD_CHKWR = 4'h5;
   localparam int TRACK_W = 11;
   localparam int SECTOR_W = 4;
   localparam int IND_W = 16;
   localparam int SYNC_STAGES = 3;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      strobe_wait_phase = 3'b000,
      strobe_ack_phase = 3'b001,
      strobe_late_phase = 3'b010,
      service_request_phase = 3'b011,
      service_phase = 3'b100,
      transfer_out_phase = 3'b101
   } phase_e;

   typedef enum logic [1:0] {
      CYC_ORDER_OUT = 2'b00,
      CYC_DATA = 2'b01,
      CYC_ORDER_IN = 2'b10
   } cycle_e;

   // Pin inputs from the processor or tester
   typedef struct packed {
      logic function_strobe;
      logic halt_indicator;
      logic device_test_indicator;
      logic io_test_indicator;
      logic start_indicator;
      logic hold_track;
      logic tester_reset;
      logic [7:0] data;
   } pins_s;
   localparam int PIN_W = $bits(pins_s);

   // Status outputs toward the processor
   typedef struct packed {
      logic [5:0] phase_hot;
      logic controller_busy_flag;
      logic data_flag;
      logic inbound_flag;
      logic unusual_end_flag;
      logic sector_unavailable_flag;
   } status_s;
endpackage

// File: test/io_tester_model.sv
// Far-side model of the processor or tester that drives the controller pins
`timescale 1ns/1ps
module io_tester_model (
   // Clock
   input wire logic pclk,
   // Controller status, watched for error stop
   input wire disc_seq_pkg::status_s status,
   // Pins toward the controller
   output disc_seq_pkg::pins_s pins
);
   import disc_seq_pkg::*;

   // ---------------------------------------------------------------
   // Pin drivers
   // ---------------------------------------------------------------
   // All pins low and idle until a task drives them
   initial pins = '0;
   // Tester counters: operations done and error sector count
   int op_count = 0;
   logic [3:0] sector_count = 4'h0;

   // Data byte, held past the input filter before anyone samples it
   task automatic set_data(input logic [7:0] b);
      @(posedge pclk);
      pins.data <= b;
      repeat (8) @(posedge pclk);
   endtask

   // Hold-track level
   task automatic set_hold(input logic h);
      @(posedge pclk);
      pins.hold_track <= h;
      repeat (8) @(posedge pclk);
   endtask

   // Command level plus strobe; 0 halt, 1 device test, 2 io test, 3 start
   task automatic issue(input int c);
      @(posedge pclk);
      pins.halt_indicator <= (c == 0);
      pins.device_test_indicator <= (c == 1);
      pins.io_test_indicator <= (c == 2);
      pins.start_indicator <= (c == 3);
      pins.function_strobe <= 1'b1;
      repeat (10) @(posedge pclk);
      pins.function_strobe <= 1'b0;
      pins[13:10] <= 4'h0;
      repeat (8) @(posedge pclk);
   endtask

   // Reset pin pulse, long enough to pass the input filter
   task automatic pulse_reset();
      @(posedge pclk);
      pins.tester_reset <= 1'b1;
      repeat (8) @(posedge pclk);
      pins.tester_reset <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask

   // One started order, optionally preceded by an automatic write
   task automatic run_order(input logic [7:0] o, input logic alt);
      if (alt) begin
         set_data({4'h0, ORD_WRITE});
         issue(3);
         repeat (40) @(posedge pclk);
      end
      set_data(o);
      issue(3);
      repeat (40) @(posedge pclk);
   endtask

   // Repeat until the preset count, or stop early on an error; then reset
   task automatic repeat_run(input logic [7:0] o, input int preset, input logic stop);
      op_count = 0;
      while (op_count < preset && !(stop && status.unusual_end_flag)) begin
         run_order(o, 1'b0);
         op_count++;
      end
      if (stop && status.unusual_end_flag) sector_count++;
      pulse_reset();
   endtask
endmodule // io_tester_model

// File: test/disc_order_phase_sequencer_test.sv
// Self-checking bench for the disc order phase sequencer
`timescale 1ns/1ps
module disc_order_phase_sequencer_test;
   import disc_seq_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr, unit_select;
   logic [31:0] pwdata, prdata, rd;
   logic [10:0] t;
   logic [IND_W-1:0] indicator_out;
   logic [16:0] rows [5];
   pins_s pins;
   status_s status_out;
   int failures, num_checks;

   // 125 MHz clock
   initial pclk = 1'b0;
   always #4 pclk = ~pclk;

   disc_order_phase_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pins_in(pins), .status_out(status_out),
      .indicator_out(indicator_out), .unit_select(unit_select));
   io_tester_model far (.pclk(pclk), .status(status_out), .pins(pins));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic summarize();
      if (failures == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; the wait for pready is bounded
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 40) begin
         n++;
         @(posedge pclk);
      end
      if (n == 40) failures++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Step pulse, then let status settle past its extra register stage
   task automatic step();
      apb(1'b1, ADDR_STEP, 32'h1);
      repeat (6) @(posedge pclk);
   endtask

   function automatic logic [10:0] st(int ph, logic b, logic d, logic i, logic u, logic s);
      return {6'b1 << ph, b, d, i, u, s};
   endfunction

   // Strobe a command and step it through; by holds order, byte0, byte1
   task automatic walk(input int cmd, input int nd, input logic [23:0] by, input logic u,
                       input logic s);
      int tot, k, c;
      tot = (cmd == 3) ? 2 + 6 * (nd + 2) : 2;
      far.set_data(by[23:16]);
      far.issue(cmd);
      cmp(32'(status_out.phase_hot), 32'h2);
      for (int i = 1; i <= tot; i++) begin
         k = (i + 3) % 6;
         c = (i - 3) / 6;
         if (i > 2 && k == 4 && c <= nd) far.set_data(by[23 - 8 * c -: 8]);
         step();
         if (i == 1) cmp(32'(status_out.phase_hot), 32'h4);
         else if (i == 2) cmp(32'(status_out), 32'(st(0, cmd == 3, 0, 0, 0, 0)));
         else if (k != 5) cmp(32'(status_out.phase_hot), 32'h1 << (k + 1));
         else if (c < nd) cmp(32'(status_out), 32'(st(0, 1, 1, 0, 0, 0)));
         else if (c == nd) cmp(32'(status_out), 32'(st(0, 1, 0, 1, u, s)));
         else cmp(32'(status_out), 32'(st(0, 0, 0, 0, u, s)));
      end
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      rows = '{{8'h05, 8'hA3, 1'b0}, {8'h85, 8'hA3, 1'b1}, {8'h45, 8'hA3, 1'b1},
               {8'h25, 8'hA3, 1'b1}, {8'h05, 8'hAC, 1'b1}};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      cmp(32'(status_out.phase_hot), 32'h1);
      apb(1'b0, ADDR_CTRL, 32'h0);
      cmp(rd, CTRL_RESET);
      apb(1'b0, 8'h10, 32'h0);
      cmp({rd[30:0], er}, 32'h1);
      for (int u = 0; u < 8; u++) begin
         apb(1'b1, ADDR_CTRL, 32'(u) << CTRL_UNIT_LO);
         repeat (2) @(posedge pclk);
         cmp(32'(unit_select), 32'h1 << u);
      end
      apb(1'b1, ADDR_CTRL, 32'h1);
      for (int c = 0; c < 3; c++) walk(c, 0, 24'h0, 1'b0, 1'b0);
      walk(3, 1, 24'h070000, 1'b1, 1'b0);
      // Seek rows: clean, overflow, both top track bits, top sector pair
      foreach (rows[r]) begin
         walk(3, 2, {8'h03, rows[r][16:1]}, rows[r][0], rows[r][0]);
         apb(1'b0, ADDR_SEEK, 32'h0);
         cmp(rd, {11'h0, rows[r][16:1], 1'b0, 4'h3});
         apb(1'b1, ADDR_CTRL, 32'h3);
         repeat (2) @(posedge pclk);
         cmp(32'(indicator_out), 32'(rows[r][16:1]));
         apb(1'b1, ADDR_CTRL, 32'h1);
         repeat (2) @(posedge pclk);
         cmp(32'(indicator_out), {16'h0, st(0, 0, 0, 0, rows[r][0], rows[r][0]), 5'h6});
      end
      // Free run over every code except seek with the track held
      apb(1'b1, ADDR_CTRL, 32'h0);
      far.set_hold(1'b1);
      apb(1'b0, ADDR_SEEK, 32'h0);
      t = rd[19:9];
      for (int o = 0; o < 16; o++) begin
         if (o == 3) continue;
         far.set_data(o[7:0]);
         far.issue(3);
         repeat (60) @(posedge pclk);
         cmp(32'(status_out), 32'(st(0, 0, 0, 0, !(o inside {1, 2, 4, 5}), 0)));
      end
      apb(1'b0, ADDR_SEEK, 32'h0);
      cmp(32'(rd[19:9]), 32'(t));
      far.set_hold(1'b0);
      far.set_data(8'h01);
      far.issue(3);
      repeat (60) @(posedge pclk);
      apb(1'b0, ADDR_SEEK, 32'h0);
      cmp(32'(rd[19:9]), 32'(t + 11'h1));
      // Tester runs: write before read, counted repeat, error stop
      far.run_order(8'h02, 1'b1);
      far.repeat_run(8'h01, 3, 1'b0);
      apb(1'b0, ADDR_SEEK, 32'h0);
      cmp(32'(rd[19:9]), 32'(t + 11'h6));
      far.repeat_run(8'h07, 3, 1'b1);
      cmp(32'(far.op_count), 32'h1);
      cmp(32'(far.sector_count), 32'h1);
      cmp(32'(status_out), 32'(st(0, 0, 0, 0, 1, 0)));
      apb(1'b0, ADDR_STATUS, 32'h0);
      cmp(rd, {19'h0, 2'b00, st(0, 0, 0, 0, 1, 0)});
      // Tester reset pin in mid-operation, busy already set
      apb(1'b1, ADDR_CTRL, 32'h1);
      far.issue(3);
      repeat (3) step();
      far.pulse_reset();
      cmp(32'(status_out), 32'(st(0, 0, 0, 0, 0, 0)));
      // Reset in mid-sequence, from the late phase
      apb(1'b1, ADDR_CTRL, 32'h1);
      far.issue(3);
      step();
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      cmp(32'(status_out), 32'(st(0, 0, 0, 0, 0, 0)));
      summarize();
   end

   // Hang guard, well beyond the expected run length
   initial begin
      #400000;
      failures++;
      summarize();
   end
endmodule // disc_order_phase_sequencer_test
